// [rtl/adv_timer_irq_dma_params.svh]
// Purpose: offsets, field positions and reset values of the timer event bank
// Assumes: included by the bank module and its testbench
// Notes: byte offsets on a 32-bit AXI4-Lite word map
`ifndef ADV_TIMER_IRQ_DMA_PARAMS_SVH
`define ADV_TIMER_IRQ_DMA_PARAMS_SVH

`define TIDS_ADDR_W 12
`define TIDS_OFF_ENABLE 12'h00C
`define TIDS_OFF_STATUS 12'h010
`define TIDS_IDX_ENABLE 10'h003
`define TIDS_IDX_STATUS 10'h004

`define TIDS_EN_RESET 16'h0000
`define TIDS_STS_RESET 16'h0000
`define TIDS_EN_MASK 16'h7FFF
`define TIDS_STS_MASK 16'h1EFF

`define TIDS_BIT_UPD 0
`define TIDS_BIT_CH1 1
`define TIDS_BIT_COMMUT 5
`define TIDS_BIT_TRIG 6
`define TIDS_BIT_BREAK 7
`define TIDS_BIT_UPD_DMA 8
`define TIDS_BIT_CH1_DMA 9
`define TIDS_BIT_OVR1 9
`define TIDS_BIT_COMMUT_DMA 13
`define TIDS_BIT_TRIG_DMA 14

`define TIDS_RESP_OKAY 2'h0
`define TIDS_RESP_SLVERR 2'h2

`endif

// [rtl/adv_timer_irq_dma_pkg.sv]
// Purpose: types shared by the timer event bank and its neighbours
// Assumes: event strobes are single-cycle pulses on clk
// Notes: the header holds every number
package adv_timer_irq_dma_pkg;

   // strobes and levels from counter, slave controller and channels
   typedef struct packed {
      logic update;
      logic [3:0] cc_capture;
      logic [3:0] cc_match;
      logic [3:0] ch_input_mode;
      logic [3:0] capture_read;
      logic center_aligned;
      logic gated_mode;
      logic trig_active_edge;
      logic trig_any_edge;
      logic commut;
      logic break_active;
   } timer_evt_t;

   // one-cycle request pulses to the DMA controller
   typedef struct packed {
      logic trig;
      logic commut;
      logic [3:0] ch;
      logic update;
   } dma_req_t;

endpackage

// [rtl/adv_timer_irq_dma_status.sv]
// Purpose: interrupt/DMA enable register and event status register of the timer
// Assumes: AXI4-Lite slave, 32-bit data, one write and one read in flight at most
// Notes: status flags clear by writing zero; hardware set wins over a clear
// Functional notes
// RQ1: trigger event raises a DMA request only while enable bit 14 is one.
// RQ2: commutation event raises a DMA request only while enable bit 13 is one.
// RQ3: enable bits 12..9 gate DMA requests of channels four..one events.
// RQ4: update event raises a DMA request only while enable bit 8 is one.
// RQ5: break interrupt needs enable bit 7 set.
// RQ6: trigger interrupt needs enable bit 6 set.
// RQ7: commutation interrupt needs enable bit 5 set.
// RQ8: enable bits 4..1 gate interrupts of channels four..one.
// RQ9: update interrupt needs enable bit 0 set.
// RQ10: enable bit 15 and status bits 15..13 always read zero.
// RQ11: overcapture flag sets on capture while event flag set, input mode only.
// RQ12: break flag follows active break input; clear only while input inactive.
// RQ13: trigger flag sets on active edge, or any edge in gated mode.
// RQ14: commutation flag sets when channel control bits load from preload.
// RQ15: output channel flag sets on compare match, not in center-aligned mode.
// RQ16: input channel flag sets on capture; cleared by software or capture read.
// RQ17: update flag sets on update event and holds until software clears it.
// RQ18: interrupt output high while any flag meets its set enable bit.
`timescale 1ns/10ps
`include "adv_timer_irq_dma_params.svh"

module adv_timer_irq_dma_status
   import adv_timer_irq_dma_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic awvalid,
   output logic awready,
   input wire logic [`TIDS_ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [`TIDS_ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire timer_evt_t evt,
   output dma_req_t dma_req,
   output logic irq
);

   logic [15:0] en_reg;
   logic [15:0] en_next;
   logic [15:0] sts_reg;
   logic [15:0] sts_next;
   logic aw_full_reg;
   logic w_full_reg;
   logic [9:0] aw_idx_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   dma_req_t dma_reg;
   logic wr_fire;
   logic wr_en_hit;
   logic wr_sts_hit;
   logic [15:0] lane_mask;
   logic [15:0] wr_clr;
   logic [3:0] ch_set;
   logic [3:0] ovr_set;
   logic trig_set;
   logic [9:0] ar_idx;

   // write channel: address and data taken in either order
   assign awready = !aw_full_reg && !bvalid_reg;
   assign wready = !w_full_reg && !bvalid_reg;
   assign wr_fire = aw_full_reg && w_full_reg;
   assign wr_en_hit = wr_fire && (aw_idx_reg == `TIDS_IDX_ENABLE);
   assign wr_sts_hit = wr_fire && (aw_idx_reg == `TIDS_IDX_STATUS);
   assign lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign wr_clr = wr_sts_hit ? (lane_mask & ~wdata_reg[15:0]) : 16'h0000;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_full_reg <= 1'b0;
         aw_idx_reg <= 10'h000;
      end else if (awvalid && awready) begin
         aw_full_reg <= 1'b1;
         aw_idx_reg <= awaddr[`TIDS_ADDR_W-1:2];
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_full_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else if (wvalid && wready) begin
         w_full_reg <= 1'b1;
         wdata_reg <= wdata;
         wstrb_reg <= wstrb;
      end else if (wr_fire) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `TIDS_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (wr_en_hit || wr_sts_hit) ? `TIDS_RESP_OKAY : `TIDS_RESP_SLVERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;

   // read channel: one word answered the cycle after the address is taken
   assign arready = !rvalid_reg;
   assign ar_idx = araddr[`TIDS_ADDR_W-1:2];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `TIDS_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= `TIDS_RESP_OKAY;
         if (ar_idx == `TIDS_IDX_ENABLE) begin
            rdata_reg <= {16'h0000, en_reg & `TIDS_EN_MASK}; // see RQ10
         end else if (ar_idx == `TIDS_IDX_STATUS) begin
            rdata_reg <= {16'h0000, sts_reg & `TIDS_STS_MASK}; // see RQ10
         end else begin
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `TIDS_RESP_SLVERR;
         end
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

   // enable register
   always_comb begin
      en_next = en_reg;
      if (wr_en_hit) begin
         en_next = ((en_reg & ~lane_mask) | (wdata_reg[15:0] & lane_mask)) & `TIDS_EN_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         en_reg <= `TIDS_EN_RESET;
      end else begin
         en_reg <= en_next;
      end
   end

   // per-channel set terms
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         if (evt.ch_input_mode[i]) begin
            ch_set[i] = evt.cc_capture[i]; // see RQ16
         end else begin
            ch_set[i] = evt.cc_match[i] && !evt.center_aligned; // see RQ15
         end
         ovr_set[i] = evt.ch_input_mode[i] && evt.cc_capture[i]
                      && sts_reg[`TIDS_BIT_CH1+i]; // see RQ11
      end
   end

   assign trig_set = evt.gated_mode ? evt.trig_any_edge : evt.trig_active_edge; // see RQ13

   // status flags: a set in the same cycle as a clear wins
   always_comb begin
      sts_next = sts_reg & ~wr_clr;
      sts_next[`TIDS_BIT_UPD] = evt.update || sts_next[`TIDS_BIT_UPD]; // see RQ17
      for (int i = 0; i < 4; i++) begin
         if (evt.ch_input_mode[i] && evt.capture_read[i]) begin
            sts_next[`TIDS_BIT_CH1+i] = 1'b0; // see RQ16
         end
         sts_next[`TIDS_BIT_CH1+i] = ch_set[i] || sts_next[`TIDS_BIT_CH1+i];
         sts_next[`TIDS_BIT_OVR1+i] = ovr_set[i] || sts_next[`TIDS_BIT_OVR1+i];
      end
      sts_next[`TIDS_BIT_COMMUT] = evt.commut || sts_next[`TIDS_BIT_COMMUT]; // see RQ14
      sts_next[`TIDS_BIT_TRIG] = trig_set || sts_next[`TIDS_BIT_TRIG];
      // an active break input keeps the flag up against any clear
      sts_next[`TIDS_BIT_BREAK] = evt.break_active || sts_next[`TIDS_BIT_BREAK]; // see RQ12
      sts_next = sts_next & `TIDS_STS_MASK; // see RQ10
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sts_reg <= `TIDS_STS_RESET;
      end else begin
         sts_reg <= sts_next;
      end
   end

   // DMA request pulses, one cycle after the event
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_reg <= '0;
      end else begin
         dma_reg.trig <= trig_set && en_reg[`TIDS_BIT_TRIG_DMA]; // see RQ1
         dma_reg.commut <= evt.commut && en_reg[`TIDS_BIT_COMMUT_DMA]; // see RQ2
         dma_reg.ch <= ch_set & en_reg[`TIDS_BIT_CH1_DMA +: 4]; // see RQ3
         dma_reg.update <= evt.update && en_reg[`TIDS_BIT_UPD_DMA]; // see RQ4
      end
   end

   assign dma_req = dma_reg;

   // interrupt: flags 7..0 each gated by the enable bit at the same place
   assign irq = |(sts_reg[7:0] & en_reg[7:0]); // see RQ5 RQ6 RQ7 RQ8 RQ9 RQ18

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   property p_trig_dma; // see RQ1
      trig_set |=> (dma_req.trig == $past(en_reg[`TIDS_BIT_TRIG_DMA]));
   endproperty
   a_trig_dma: assert property (p_trig_dma) else $error("trigger dma request wrong"); // see RQ1

   property p_commut_dma; // see RQ2
      !evt.commut |=> !dma_req.commut;
   endproperty
   a_commut_dma: assert property (p_commut_dma) else $error("stray commutation dma"); // see RQ2

   property p_ch_dma; // see RQ3
      1'b1 |=> (dma_req.ch == $past(ch_set & en_reg[`TIDS_BIT_CH1_DMA +: 4]));
   endproperty
   a_ch_dma: assert property (p_ch_dma) else $error("channel dma request wrong"); // see RQ3

   property p_upd_dma; // see RQ4
      evt.update && en_reg[`TIDS_BIT_UPD_DMA] |=> dma_req.update;
   endproperty
   a_upd_dma: assert property (p_upd_dma) else $error("update dma request missing"); // see RQ4

   property p_irq_on; // see RQ18
      (sts_reg[7:0] & en_reg[7:0]) != 8'h00 |-> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt missing"); // see RQ18

   property p_irq_off; // see RQ5
      irq |-> (sts_reg[7:0] & en_reg[7:0]) != 8'h00;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt without enabled flag"); // see RQ5

   property p_reserved; // see RQ10
      rvalid |-> (rdata[31:16] == 16'h0000) && (sts_reg[15:13] == 3'h0) && !en_reg[15];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // see RQ10

   property p_ovr1; // see RQ11
      evt.ch_input_mode[0] && evt.cc_capture[0] && sts_reg[`TIDS_BIT_CH1]
         |=> sts_reg[`TIDS_BIT_OVR1];
   endproperty
   a_ovr1: assert property (p_ovr1) else $error("overcapture not flagged"); // see RQ11

   property p_break_hold; // see RQ12
      evt.break_active |=> sts_reg[`TIDS_BIT_BREAK];
   endproperty
   a_break_hold: assert property (p_break_hold) else $error("break flag dropped"); // see RQ12

   property p_trig_gated; // see RQ13
      evt.gated_mode && evt.trig_any_edge |=> sts_reg[`TIDS_BIT_TRIG];
   endproperty
   a_trig_gated: assert property (p_trig_gated) else $error("trigger flag missed"); // see RQ13

   property p_match1; // see RQ15
      !evt.ch_input_mode[0] && evt.cc_match[0] && !evt.center_aligned
         |=> sts_reg[`TIDS_BIT_CH1];
   endproperty
   a_match1: assert property (p_match1) else $error("compare flag missed"); // see RQ15

   property p_capread1; // see RQ16
      evt.ch_input_mode[0] && evt.capture_read[0] && !evt.cc_capture[0]
         |=> !sts_reg[`TIDS_BIT_CH1];
   endproperty
   a_capread1: assert property (p_capread1) else $error("capture read did not clear"); // see RQ16

   sequence s_upd_set;
      evt.update ##1 sts_reg[`TIDS_BIT_UPD];
   endsequence

   sequence s_no_clear;
      !wr_clr[`TIDS_BIT_UPD] [*2];
   endsequence

   property p_upd_hold; // see RQ17
      s_no_clear and s_upd_set |=> sts_reg[`TIDS_BIT_UPD];
   endproperty
   a_upd_hold: assert property (p_upd_hold) else $error("update flag not held"); // see RQ17

   property p_irq_upd; // see RQ9
      evt.update && en_reg[`TIDS_BIT_UPD] && !wr_en_hit |=> irq;
   endproperty
   a_irq_upd: assert property (p_irq_upd) else $error("update interrupt missing"); // see RQ9

   property p_irq_ch; // see RQ8
      (ch_set & en_reg[`TIDS_BIT_CH1 +: 4]) != 4'h0 && !wr_en_hit |=> irq;
   endproperty
   a_irq_ch: assert property (p_irq_ch) else $error("channel interrupt missing"); // see RQ8

   property p_irq_commut; // see RQ7
      evt.commut && en_reg[`TIDS_BIT_COMMUT] && !wr_en_hit |=> irq;
   endproperty
   a_irq_commut: assert property (p_irq_commut) else $error("commutation interrupt missing"); // see RQ7

   property p_irq_trig; // see RQ6
      trig_set && en_reg[`TIDS_BIT_TRIG] && !wr_en_hit |=> irq;
   endproperty
   a_irq_trig: assert property (p_irq_trig) else $error("trigger interrupt missing"); // see RQ6

   property p_irq_break; // see RQ5
      evt.break_active && en_reg[`TIDS_BIT_BREAK] && !wr_en_hit |=> irq;
   endproperty
   a_irq_break: assert property (p_irq_break) else $error("break interrupt missing"); // see RQ5

   property p_trig_dma_off; // see RQ1
      !en_reg[`TIDS_BIT_TRIG_DMA] |=> !dma_req.trig;
   endproperty
   a_trig_dma_off: assert property (p_trig_dma_off) else $error("stray trigger dma"); // see RQ1

   property p_commut_dma_on; // see RQ2
      evt.commut && en_reg[`TIDS_BIT_COMMUT_DMA] |=> dma_req.commut;
   endproperty
   a_commut_dma_on: assert property (p_commut_dma_on) else $error("commutation dma missing"); // see RQ2

   property p_upd_dma_off; // see RQ4
      !en_reg[`TIDS_BIT_UPD_DMA] |=> !dma_req.update;
   endproperty
   a_upd_dma_off: assert property (p_upd_dma_off) else $error("stray update dma"); // see RQ4

   property p_ovr_output; // see RQ11
      !evt.ch_input_mode[0] && !sts_reg[`TIDS_BIT_OVR1] |=> !sts_reg[`TIDS_BIT_OVR1];
   endproperty
   a_ovr_output: assert property (p_ovr_output) else $error("overcapture in output mode"); // see RQ11

   property p_break_clear; // see RQ12
      !evt.break_active && wr_clr[`TIDS_BIT_BREAK] |=> !sts_reg[`TIDS_BIT_BREAK];
   endproperty
   a_break_clear: assert property (p_break_clear) else $error("break flag not cleared"); // see RQ12

   property p_trig_edge; // see RQ13
      !evt.gated_mode && evt.trig_active_edge |=> sts_reg[`TIDS_BIT_TRIG];
   endproperty
   a_trig_edge: assert property (p_trig_edge) else $error("trigger edge missed"); // see RQ13

   property p_commut_flag; // see RQ14
      evt.commut |=> sts_reg[`TIDS_BIT_COMMUT];
   endproperty
   a_commut_flag: assert property (p_commut_flag) else $error("commutation flag missed"); // see RQ14

   property p_center1; // see RQ15
      !evt.ch_input_mode[0] && evt.center_aligned && !sts_reg[`TIDS_BIT_CH1]
         |=> !sts_reg[`TIDS_BIT_CH1];
   endproperty
   a_center1: assert property (p_center1) else $error("compare flag in center mode"); // see RQ15

   property p_upd_set; // see RQ17
      evt.update |=> sts_reg[`TIDS_BIT_UPD];
   endproperty
   a_upd_set: assert property (p_upd_set) else $error("update flag missed"); // see RQ17

endmodule // adv_timer_irq_dma_status

// [testbench/dma_req_sink.sv]
// Purpose: stand-in for the DMA controller, counts request pulses per line
// Assumes: requests are one-cycle pulses sampled on clk
// Notes: eight-bit counts are plenty for the short traffic of the bench
`timescale 1ns/10ps
module dma_req_sink
   import adv_timer_irq_dma_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire dma_req_t dma_req,
   output logic [6:0][7:0] req_count
);
   logic [6:0] req_bits;
   assign req_bits = dma_req;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req_count <= '0;
      end else begin
         for (int k = 0; k < 7; k++) begin
            if (req_bits[k]) begin
               req_count[k] <= req_count[k] + 8'h01;
            end
         end
      end
   end
endmodule // dma_req_sink

// [testbench/tb_adv_timer_irq_dma_status.sv]
// Purpose: self-checking bench of the timer event bank over AXI4-Lite
// Assumes: event strobes driven one cycle wide, levels held in lvl
// Notes: dma counts are checked once at the end against expected totals
`timescale 1ns/10ps
`include "adv_timer_irq_dma_params.svh"
module tb_adv_timer_irq_dma_status
   import adv_timer_irq_dma_pkg::*;
;
   logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb, strb;
   logic [1:0] bresp, rresp, r;
   timer_evt_t evt, lvl, all_p, e;
   dma_req_t dma_req;
   logic [6:0][7:0] req_count;
   int num_errors, comparisons;
   adv_timer_irq_dma_status uut (.clk(clk), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .evt(evt), .dma_req(dma_req), .irq(irq));
   dma_req_sink sink (.clk(clk), .rst_b(rst_b), .dma_req(dma_req), .req_count(req_count));
   always #25 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] dv, output logic [1:0] rs);
      int n;
      n = 0;
      rs = 2'h3;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= dv;
      wstrb <= strb;
      bready <= 1'b1;
      while (rs === 2'h3 && n < 40) begin
         @(posedge clk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            rs = bresp;
         end
      end
      if (rs === 2'h3) chk({30'h0, rs}, 32'h0);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] dv, output logic [1:0] rs);
      int n;
      n = 0;
      rs = 2'h3;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (rs === 2'h3 && n < 40) begin
         @(posedge clk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            rs = rresp;
            dv = rdata;
         end
      end
      if (rs === 2'h3) chk({30'h0, rs}, 32'h0);
   endtask
   task automatic fire(input timer_evt_t ev);
      @(posedge clk);
      evt <= timer_evt_t'(lvl | ev);
      @(posedge clk);
      evt <= lvl;
      @(negedge clk);
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #150000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      clk = 0; rst_b = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; evt = '0; lvl = '0; strb = 4'hF;
      all_p = '0; all_p.update = 1; all_p.cc_match = 4'hF; all_p.commut = 1;
      all_p.trig_active_edge = 1;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(`TIDS_OFF_ENABLE, d, r); chk(d, 32'h0);
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0);
      rd(12'h020, d, r); chk({30'h0, r}, {30'h0, `TIDS_RESP_SLVERR}); chk(d, 32'h0);
      wr(12'h024, 32'hFFFF, r); chk({30'h0, r}, {30'h0, `TIDS_RESP_SLVERR});
      wr(`TIDS_OFF_ENABLE, 32'hFFFF, r); rd(`TIDS_OFF_ENABLE, d, r); chk(d, 32'h7FFF);
      wr(`TIDS_OFF_ENABLE, 32'h0, r);
      fire(all_p); chk({31'h0, irq}, 32'h0);
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h007F);
      for (int i = 0; i < 7; i++) begin
         wr(`TIDS_OFF_ENABLE, 32'h1 << i, r); chk({31'h0, irq}, 32'h1);
         wr(`TIDS_OFF_STATUS, 32'hFFFF ^ (32'h1 << i), r); chk({31'h0, irq}, 32'h0);
      end
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0);
      for (int k = 0; k < 7; k++) begin
         wr(`TIDS_OFF_ENABLE, 32'h100 << k, r);
         fire(all_p);
         wr(`TIDS_OFF_STATUS, 32'h0, r);
      end
      wr(`TIDS_OFF_ENABLE, 32'h007F, r); fire(all_p); chk({31'h0, irq}, 32'h1);
      wr(`TIDS_OFF_STATUS, 32'h0, r); chk({31'h0, irq}, 32'h0);
      strb = 4'h2;
      wr(`TIDS_OFF_ENABLE, 32'hFFFF, r);
      strb = 4'hF;
      rd(`TIDS_OFF_ENABLE, d, r); chk(d, 32'h7F7F);
      lvl.center_aligned = 1'b1;
      wr(`TIDS_OFF_ENABLE, 32'h0202, r);
      e = '0; e.cc_match = 4'h1; fire(e);
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0);
      lvl.center_aligned = 1'b0; lvl.gated_mode = 1'b1;
      e = '0; e.trig_active_edge = 1; fire(e);
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0);
      e = '0; e.trig_any_edge = 1; fire(e);
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0040);
      lvl.gated_mode = 1'b0; lvl.ch_input_mode = 4'hF;
      wr(`TIDS_OFF_STATUS, 32'h0, r);
      e = '0; e.cc_capture = 4'h1; fire(e); fire(e);
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0202);
      wr(`TIDS_OFF_STATUS, 32'hFDFF, r); rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0002);
      e = '0; e.capture_read = 4'h1; fire(e);
      rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0);
      lvl.break_active = 1'b1; fire('0);
      wr(`TIDS_OFF_ENABLE, 32'h0080, r); chk({31'h0, irq}, 32'h1);
      wr(`TIDS_OFF_STATUS, 32'h0, r); rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0080);
      lvl.break_active = 1'b0; fire('0);
      wr(`TIDS_OFF_STATUS, 32'h0, r); rd(`TIDS_OFF_STATUS, d, r); chk(d, 32'h0);
      chk({31'h0, irq}, 32'h0);
      for (int k = 0; k < 7; k++) begin
         chk({24'h0, req_count[k]}, (k == 1) ? 32'h3 : 32'h1);
      end
      tally_and_finish();
   end
endmodule // tb_adv_timer_irq_dma_status
